//--- include/rst_seq_pkg.sv
// package for the transceiver reset sequencer: states, pin groups, widths
// assumes a single free-running clock shared by sequencer and transceiver user side
package rst_seq_pkg;

  // one-hot state codes of the sequencer
  typedef enum logic [5:0] {
    ST_TX_PULSE = 6'h01,
    ST_TX_WAIT  = 6'h02,
    ST_TX_DONE  = 6'h04,
    ST_RX_PULSE = 6'h08,
    ST_RX_WAIT  = 6'h10,
    ST_RUN      = 6'h20
  } seq_state_e;

  // reset pulse length in cycles
  localparam int unsigned PULSE_CYCLES = 1;
  // width of the done-flag synchroniser chain
  localparam int unsigned SYNC_STAGES = 2;

  // reset outputs towards the transceiver
  typedef struct packed {
    logic tx_rst;
    logic rx_rst;
  } xcvr_rst_s;

  // completion flags coming back from the transceiver
  typedef struct packed {
    logic tx_done;
    logic rx_done;
  } xcvr_done_s;

  // readiness towards the user logic
  typedef struct packed {
    logic tx_ready;
    logic rx_ready;
  } user_ready_s;

endpackage : rst_seq_pkg

//--- logic/done_sync.sv
// two-stage synchroniser for the transceiver completion flags
// assumes the flags are levels that stay high once raised
`timescale 1ns/100ps
module done_sync
  import rst_seq_pkg::*;
#(
  parameter int unsigned STAGES = SYNC_STAGES
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  // flags
  input wire xcvr_done_s done_i,
  output xcvr_done_s done_o
);

  // fewer than two stages gives no metastability settling time
  if (STAGES < 2) begin : g_bad_stages
    $error("done_sync needs at least two stages");
  end

  logic [STAGES-1:0] tx_chain_reg;
  logic [STAGES-1:0] rx_chain_reg;

  // shift chain; only the last stage is read outside
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tx_chain_reg <= '0;
      rx_chain_reg <= '0;
    end else begin
      tx_chain_reg <= {tx_chain_reg[STAGES-2:0], done_i.tx_done};
      rx_chain_reg <= {rx_chain_reg[STAGES-2:0], done_i.rx_done};
    end
  end

  assign done_o.tx_done = tx_chain_reg[STAGES-1];
  assign done_o.rx_done = rx_chain_reg[STAGES-1];

endmodule : done_sync

//--- logic/transceiver_reset_sequencer.sv
// transceiver reset sequencer for a transceiver with bypassed tx and rx buffers
// assumes the transceiver done flags are levels; one clock at 250 MHz
`timescale 1ns/100ps

module transceiver_reset_sequencer
  import rst_seq_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  // transceiver side
  output xcvr_rst_s xcvr_rst_o,
  input wire xcvr_done_s xcvr_done_i,
  // user side
  output user_ready_s user_ready_o
);

  seq_state_e state_reg;
  seq_state_e state_next;
  xcvr_done_s done_sync_w;
  logic tx_rst_reg;
  logic rx_rst_reg;
  logic tx_ready_reg;
  logic rx_ready_reg;

  // flags arrive from the transceiver's own logic, so resynchronise them
  done_sync #(
    .STAGES(SYNC_STAGES)
  ) u_done_sync (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .done_i(xcvr_done_i),
    .done_o(done_sync_w)
  );

  // true when the wait state in hand has seen its own completion flag; a flag that
  // belongs to the other phase is ignored, so an early rx done cannot skip the tx wait
  function automatic logic phase_done(input seq_state_e st, input xcvr_done_s d);
    logic hit;
    hit = 1'h0;
    case (st)
      ST_TX_WAIT: hit = d.tx_done;
      ST_RX_WAIT: hit = d.rx_done;
      default: hit = 1'h0;
    endcase
    return hit;
  endfunction : phase_done

  // the pulse state is kept for exactly one cycle, so the pulse length is fixed
  if (PULSE_CYCLES != 1) begin : g_bad_pulse
    $error("transceiver_reset_sequencer only serves one-cycle reset pulses");
  end

  // next-state decode
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_TX_PULSE: state_next = ST_TX_WAIT;
      ST_TX_WAIT: begin
        if (phase_done(state_reg, done_sync_w)) begin
          state_next = ST_TX_DONE;
        end
      end
      ST_TX_DONE: state_next = ST_RX_PULSE;
      ST_RX_PULSE: state_next = ST_RX_WAIT;
      ST_RX_WAIT: begin
        if (phase_done(state_reg, done_sync_w)) begin
          state_next = ST_RUN;
        end
      end
      ST_RUN: state_next = ST_RUN;
      default: state_next = ST_TX_PULSE;
    endcase
  end

  // state register; reset always restarts at the tx pulse
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_reg <= ST_TX_PULSE;
    end else begin
      state_reg <= state_next;
    end
  end

  // reset outputs are registered so they are glitch free at the pins and low in reset;
  // tx reset follows the pulse state by one cycle, rx reset lines up with its state
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tx_rst_reg <= 1'h0;
      rx_rst_reg <= 1'h0;
    end else begin
      tx_rst_reg <= (state_reg == ST_TX_PULSE);
      rx_rst_reg <= (state_next == ST_RX_PULSE);
    end
  end

  // ready flags; they only rise and drop solely on reset
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tx_ready_reg <= 1'h0;
      rx_ready_reg <= 1'h0;
    end else begin
      if (state_next == ST_TX_DONE) begin
        tx_ready_reg <= 1'h1;
      end
      if (state_next == ST_RUN) begin
        rx_ready_reg <= 1'h1;
      end
    end
  end

  // pins come straight from flops, so they hold no decode glitches
  assign xcvr_rst_o.tx_rst = tx_rst_reg;
  assign xcvr_rst_o.rx_rst = rx_rst_reg;
  assign user_ready_o.tx_ready = tx_ready_reg;
  assign user_ready_o.rx_ready = rx_ready_reg;

  // checks; all of them sleep while the sequencer is in reset

  // tx reset is a single-cycle pulse
  chk_tx_one_cycle: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    $rose(xcvr_rst_o.tx_rst) |=> !xcvr_rst_o.tx_rst)
    else $error("tx reset longer than one cycle");

  // the tx pulse only stands in the cycle right after the pulse state
  chk_tx_rst_place: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    xcvr_rst_o.tx_rst |-> state_reg == ST_TX_WAIT && !tx_ready_reg)
    else $error("tx reset outside the start of tx wait");

  // the pulse state is left after one cycle
  chk_tx_pulse_leave: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    state_reg == ST_TX_PULSE |=> state_reg == ST_TX_WAIT && xcvr_rst_o.tx_rst)
    else $error("tx pulse state did not pulse");

  // tx wait holds until its flag arrives
  chk_tx_wait_hold: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (state_reg == ST_TX_WAIT && !done_sync_w.tx_done) |=> state_reg == ST_TX_WAIT)
    else $error("left tx wait without done");

  // tx ready rises straight after the tx flag is seen
  chk_tx_ready_rise: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (state_reg == ST_TX_WAIT && done_sync_w.tx_done) |=> tx_ready_reg && !xcvr_rst_o.tx_rst)
    else $error("tx ready not raised after done");

  // tx ready stays up once raised
  chk_tx_ready_hold: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    tx_ready_reg |=> tx_ready_reg)
    else $error("tx ready dropped without reset");

  // rx reset only after the tx phase
  chk_rx_after_tx: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    xcvr_rst_o.rx_rst |-> tx_ready_reg)
    else $error("rx reset before tx phase finished");

  // rx reset stands exactly in the rx pulse state
  chk_rx_rst_place: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    xcvr_rst_o.rx_rst == (state_reg == ST_RX_PULSE))
    else $error("rx reset and rx pulse state disagree");

  // rx reset is a single-cycle pulse
  chk_rx_one_cycle: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    xcvr_rst_o.rx_rst |=> !xcvr_rst_o.rx_rst)
    else $error("rx reset longer than one cycle");

  // rx wait holds until its flag arrives
  chk_rx_wait_hold: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (state_reg == ST_RX_WAIT && !done_sync_w.rx_done) |=> state_reg == ST_RX_WAIT && !rx_ready_reg)
    else $error("left rx wait without done");

  // rx ready rises straight after the rx flag is seen
  chk_rx_ready_rise: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (state_reg == ST_RX_WAIT && done_sync_w.rx_done) |=> rx_ready_reg ##1 rx_ready_reg)
    else $error("rx ready not raised after done");

  // the run state is final until reset
  chk_run_hold: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    state_reg == ST_RUN |=> state_reg == ST_RUN && rx_ready_reg && !xcvr_rst_o.rx_rst)
    else $error("run state left without reset");

  // rx ready implies a finished tx phase and quiet resets
  chk_ready_order: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    rx_ready_reg |-> tx_ready_reg && !xcvr_rst_o.rx_rst && !xcvr_rst_o.tx_rst)
    else $error("rx ready without tx ready");

  // both ready flags stay low while the tx phase is still running
  chk_ready_low: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (state_reg == ST_TX_PULSE || state_reg == ST_TX_WAIT) |-> !tx_ready_reg && !rx_ready_reg)
    else $error("ready raised before tx phase ended");

  // exactly one state bit is set at any time
  chk_state_onehot: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    $onehot(state_reg))
    else $error("state register not one-hot");

  // main scenarios
  cov_tx_done: cover property (@(posedge ref_clk_i) disable iff (!nrst_i) $rose(tx_ready_reg));
  cov_rx_pulse: cover property (@(posedge ref_clk_i) disable iff (!nrst_i) $rose(xcvr_rst_o.rx_rst));
  cov_run: cover property (@(posedge ref_clk_i) disable iff (!nrst_i) $rose(rx_ready_reg));
  // a slow transceiver keeps the sequencer waiting
  cov_long_wait: cover property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (state_reg == ST_TX_WAIT) [*8]);

endmodule : transceiver_reset_sequencer

//--- tb/xcvr_model.sv
// transceiver model: each done flag rises a set delay after its reset pulse
// assumes the bench holds the delay steady through one sequence
`timescale 1ns/100ps
module xcvr_model
  import rst_seq_pkg::*;
(
  // clock, reset and delay
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic [3:0] dly_i,
  // transceiver pins
  input wire xcvr_rst_s rst_i,
  output xcvr_done_s done_o
);
  logic [4:0] tx_cnt_reg;
  logic [4:0] rx_cnt_reg;
  // 1F is idle; a pulse clears the flag, which then rises and holds
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tx_cnt_reg <= 5'h1F;
      rx_cnt_reg <= 5'h1F;
    end else begin
      if (rst_i.tx_rst) tx_cnt_reg <= {1'b0, dly_i};
      else if (tx_cnt_reg != 5'h1F && tx_cnt_reg != 5'h00) tx_cnt_reg <= tx_cnt_reg - 5'h01;
      if (rst_i.rx_rst) rx_cnt_reg <= {1'b0, dly_i};
      else if (rx_cnt_reg != 5'h1F && rx_cnt_reg != 5'h00) rx_cnt_reg <= rx_cnt_reg - 5'h01;
    end
  end
  // levels held high until the next pulse or reset
  assign done_o.tx_done = (tx_cnt_reg == 5'h00);
  assign done_o.rx_done = (rx_cnt_reg == 5'h00);
endmodule : xcvr_model

//--- tb/tb.sv
// bench: runs full and aborted reset sequences against the transceiver model
// assumes outputs settle before the falling edge, where they are sampled
`timescale 1ns/100ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin miscompares++; \
  $display("unexpected %s expected %0d seen %0d", n, e, g); end end
module tb;
  import rst_seq_pkg::*;
  logic ref_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [3:0] dly = 4'h0;
  xcvr_rst_s xrst;
  xcvr_done_s xdone;
  user_ready_s rdy;
  int seed = 32'hb8775e7b;
  int miscompares = 0;
  int compares = 0;
  int cyc = 0;
  int ticks = 0;
  int t[6];
  int n[2];
  always #2 ref_clk_i = ~ref_clk_i;
  transceiver_reset_sequencer u_dut (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
    .xcvr_rst_o(xrst), .xcvr_done_i(xdone), .user_ready_o(rdy));
  xcvr_model u_xcvr (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .dly_i(dly),
    .rst_i(xrst), .done_o(xdone));
  task report_and_stop();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : report_and_stop
  // edges since release; the ceiling cuts a hung run short
  always @(posedge ref_clk_i) begin
    cyc = nrst_i ? cyc + 1 : 0;
    ticks++;
    if (ticks == 3000) begin
      miscompares++;
      report_and_stop();
    end
  end
  // first rise of each pin and pulse widths, sampled mid-cycle to avoid races
  always @(negedge ref_clk_i) begin
    logic [5:0] v;
    v = {rdy.rx_ready, xdone.rx_done, xrst.rx_rst, rdy.tx_ready, xdone.tx_done, xrst.tx_rst};
    for (int i = 0; i < 6; i++) if (v[i] === 1'b1 && t[i] == 0) t[i] = cyc;
    n[0] += (xrst.tx_rst === 1'b1);
    n[1] += (xrst.rx_rst === 1'b1);
  end
  // one sequence; abort cuts it by a reset in mid-run
  task automatic run(input logic [3:0] d, input int abort);
    nrst_i <= 1'b0;
    dly <= d;
    repeat (4) @(posedge ref_clk_i);
    `CHK("outputs in reset", 4'h0, {xrst, rdy})
    t = '{default: 0};
    n = '{default: 0};
    nrst_i <= 1'b1;
    if (abort > 0) begin
      repeat (abort) @(posedge ref_clk_i);
      @(negedge ref_clk_i);
      `CHK("tx_rst cycle cut", 1, t[0])
      `CHK("rx_ready cut", 1'b0, rdy.rx_ready)
      $display("test abort %0d done", abort);
      return;
    end
    for (int i = 0; i < 80 && rdy.rx_ready !== 1'b1; i++) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    `CHK("tx_rst cycle", 1, t[0])
    `CHK("tx_rst width", 1, n[0])
    `CHK("tx_ready cycle", t[1] + 3, t[2])
    `CHK("rx_rst cycle", t[1] + 4, t[3])
    `CHK("rx_rst width", 1, n[1])
    `CHK("rx_ready cycle", t[4] + 3, t[5])
    `CHK("resets at end", 2'b00, xrst)
    $display("test delay %0d done", d);
  endtask : run
  initial begin
    run(4'h0, 0);
    run(4'hF, 0);
    run(4'h5, 3);
    run(4'h5, 13);
    for (int k = 0; k < 8; k++) run($random(seed), 0);
    report_and_stop();
  end
endmodule : tb
